// File: rtl/pcf_port.sv
// Notes on behaviour
// - Static rx master clock pin: tx master clock drives all rx master timing.
// - At 1.544 MHz the 193rd master pulse per frame is absorbed.
// - Tx sync starts encoding, rx sync starts decoding, both synchronous to bit clocks.
// - After reset the port assumes short frame mode.
// - Short: sync at falling edge, then eight rising edges shift, float next fall.
// - Short rx: sign on next falling edge, seven more after; tx clock when synchronous.
// - Short or long is judged from the tx sync width only.
// - Long: output enabled at the first bit clock rise with sync high, sign first, seven more.
// - Long: float at later of fall after eighth rise or sync falling.
// - Long rx: eight falling edges after sync rise capture data.
// - Both frame modes work with synchronous and asynchronous clocking.
// - Each tx sync samples and encodes; the code goes out one frame later.
// - Encode and decode use mu-law or A-law by variant.
// - Decoder output updates 10 us after the rx slot ends.
// - Code points: full scale, zero and negative full scale per law.
// - Slot indicator pulled low during the tx encoder slot.
// - Tx output stays floating until the second tx sync.
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module pcf_sync3 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q_r
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      q_r  <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= (q_r & (s2_r ^ s3_r)) | (s3_r & ~(s2_r ^ s3_r));
    end
  end
endmodule : pcf_sync3

////////////////////////////////////////////////////////////////////////////////
module pcf_static_det
  import pcf_pkg::*;
(
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic lvl,
  output logic      static_r
);
  localparam int CW = $clog2(STATIC_CYC + 1);
  localparam logic [CW-1:0] LIM = CW'(STATIC_CYC);
  logic          prev_r;
  logic [CW-1:0] cnt_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_r   <= 1'b0;
      cnt_r    <= '0;
      static_r <= 1'b0;
    end else begin
      prev_r <= lvl;
      if (lvl != prev_r) begin
        cnt_r    <= '0;
        static_r <= 1'b0;
      end else if (cnt_r != LIM) begin
        cnt_r <= cnt_r + 1'b1;
      end else begin
        static_r <= 1'b1;
      end
    end
  end
endmodule : pcf_static_det

////////////////////////////////////////////////////////////////////////////////
module pcf_port
  import pcf_pkg::*;
#(
  parameter bit LAW_A = 1'b0
) (
  input  wire logic    ref_clk,
  input  wire logic    nrst,
  input  wire logic    txBitClk,
  input  wire logic    txFrameSync,
  input  wire logic    txMasterClock,
  input  wire logic    rxBitClockOrRateSelect,
  input  wire logic    rxFrameSync,
  input  wire logic    rxData,
  input  wire logic    rxMasterClockOrPowerdown,
  input  wire pcfLin_t sampleIn,
  output logic         txDataOut,
  output logic         txDataOe,
  output logic         txSlotIndicatorNOut,
  output logic         txSlotIndicatorNOe,
  output pcfLin_t      rxSample,
  output logic         rxSampleStrobe,
  output logic         frameTimingOk
);
  localparam int DW = $clog2(DECODE_CYC + 1);
  localparam logic [DW-1:0] DEC_CNT = DW'(DECODE_CYC);
  localparam int DEC_WAIT = DECODE_CYC;
  localparam int SW = $bits(pcfPins_t) + 2;

  // link side, bit clock domain
  logic       fsFall_r;
  logic       fsRiseP_r;
  logic       seen_r;
  logic       startS_r;
  logic       evtTgl_r;
  logic [1:0] hiCnt_r;
  logic       longMode_r;
  logic       oeRise_r;
  logic       oeFall_r;
  logic [3:0] bitCnt_r;
  pcfCode_t   shift_r;
  pcfCode_t   txBuf_r;
  logic       wordTglT;
  logic       wordPrev_r;
  logic       fsRiseN;
  logic       startLong;
  logic       busy;
  // system side
  pcfPins_t   pinIn;
  pcfPins_t   pinF;
  logic [SW-1:0] syncQ;
  logic       evtTglS;
  logic       longModeS;
  logic       rxBclkStatic;
  logic       mclkRxStatic;
  logic       bclkR;
  logic       mclkSel;
  logic       hiRate;
  logic       bclkPrev_r;
  logic       mclkPrev_r;
  logic       rxFsPrev_r;
  logic       evtPrev_r;
  logic       bclkFall;
  logic       mclkRise;
  logic       rxFsRise;
  logic       frameEvt;
  logic       longArm;
  logic       decGo;
  pcfCode_t   txWord_r;
  logic       wordTgl_r;
  logic [8:0] tickCnt_r;
  logic       rxAct_r;
  logic [2:0] rxCnt_r;
  logic       rxFsFall_r;
  pcfCode_t   rxShift_r;
  pcfCode_t   rxCode_r;
  logic [DW-1:0] decCnt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // transmit side, sync sampled on falling edges, and on rising edges for a long start

  assign fsRiseN   = txFrameSync & ~fsFall_r;
  assign startLong = longMode_r & txFrameSync & ~fsRiseP_r & seen_r;
  assign busy      = (bitCnt_r != 4'h0) && (bitCnt_r != BIT_LAST);
  // two toggle flops, one per edge: enable on a rise, release on a fall
  assign txDataOe  = oeRise_r ^ oeFall_r;

  always_ff @(negedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      fsFall_r <= 1'b0;
      seen_r   <= 1'b0;
      startS_r <= 1'b0;
      evtTgl_r <= 1'b0;
    end else begin
      fsFall_r <= txFrameSync;
      startS_r <= fsRiseN & seen_r & ~longMode_r;
      if (fsRiseN) begin
        seen_r   <= 1'b1;
        evtTgl_r <= ~evtTgl_r;
      end
    end
  end

  // long is set at the third high fall of a pulse, short only at the end of a shorter pulse; reset gives short
  always_ff @(negedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      hiCnt_r    <= 2'h0;
      longMode_r <= 1'b0;
    end else if (txFrameSync) begin
      if (hiCnt_r != HI_SAT) hiCnt_r <= hiCnt_r + 2'h1;
      if (hiCnt_r == HI_LONG) longMode_r <= 1'b1;
    end else begin
      hiCnt_r <= 2'h0;
      if (hiCnt_r != 2'h0 && hiCnt_r != HI_SAT) longMode_r <= 1'b0;
    end
  end

  always_ff @(negedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      oeFall_r <= 1'b0;
    end else if (txDataOe && bitCnt_r == BIT_LAST && (!longMode_r || !txFrameSync)) begin
      oeFall_r <= ~oeFall_r;
    end
  end

  always_ff @(posedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      fsRiseP_r          <= 1'b0;
      bitCnt_r           <= 4'h0;
      shift_r            <= '0;
      txDataOut          <= 1'b0;
      oeRise_r           <= 1'b0;
      txSlotIndicatorNOe <= 1'b0;
    end else begin
      fsRiseP_r <= txFrameSync;
      if ((startS_r | startLong) && !busy) begin
        txDataOut <= txBuf_r[CODE_W-1];
        shift_r   <= txBuf_r << 1;
        bitCnt_r  <= BIT_FIRST;
        if (!txDataOe) oeRise_r <= ~oeRise_r;
        txSlotIndicatorNOe <= 1'b1;
      end else if (busy) begin
        txDataOut <= shift_r[CODE_W-1];
        shift_r   <= shift_r << 1;
        bitCnt_r  <= bitCnt_r + 4'h1;
      end else begin
        txSlotIndicatorNOe <= 1'b0;
      end
    end
  end

  // open-drain slot pin only ever pulls low
  always_ff @(posedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      txSlotIndicatorNOut <= 1'b0;
    end else begin
      txSlotIndicatorNOut <= 1'b0;
    end
  end

  pcf_sync3 #(.W(1)) uWordSync (
    .clk  (txBitClk),
    .nrst (nrst),
    .d    (wordTgl_r),
    .q_r  (wordTglT)
  );

  // the word is held for a whole frame, long after its toggle arrives here
  always_ff @(posedge txBitClk or negedge nrst) begin
    if (!nrst) begin
      wordPrev_r <= 1'b0;
      txBuf_r    <= '0;
    end else begin
      wordPrev_r <= wordTglT;
      if (wordTglT != wordPrev_r) txBuf_r <= txWord_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // system side: pins and link state brought over to ref_clk

  assign pinIn = {rxBitClockOrRateSelect, rxFrameSync, rxData, rxMasterClockOrPowerdown,
                  txMasterClock, txBitClk};

  pcf_sync3 #(.W(SW)) uPinSync (
    .clk  (ref_clk),
    .nrst (nrst),
    .d    ({evtTgl_r, longMode_r, pinIn}),
    .q_r  (syncQ)
  );

  assign evtTglS   = syncQ[SW-1];
  assign longModeS = syncQ[SW-2];
  assign pinF      = syncQ[SW-3:0];

  pcf_static_det uRxBclkDet (
    .clk      (ref_clk),
    .nrst     (nrst),
    .lvl      (pinF.rxBclk),
    .static_r (rxBclkStatic)
  );

  pcf_static_det uMclkDet (
    .clk      (ref_clk),
    .nrst     (nrst),
    .lvl      (pinF.mclkRx),
    .static_r (mclkRxStatic)
  );

  assign bclkR    = rxBclkStatic ? pinF.txBclk : pinF.rxBclk;
  assign mclkSel  = mclkRxStatic ? pinF.mclkTx : pinF.mclkRx;
  assign hiRate   = LAW_A ? (~rxBclkStatic | pinF.rxBclk) : (rxBclkStatic & ~pinF.rxBclk);
  assign bclkFall = bclkPrev_r & ~bclkR;
  assign mclkRise = mclkSel & ~mclkPrev_r;
  assign rxFsRise = pinF.rxFs & ~rxFsPrev_r;
  assign frameEvt = evtTglS ^ evtPrev_r;
  assign longArm  = longModeS & rxFsRise;
  assign decGo    = bclkFall & rxAct_r & (rxCnt_r == RX_LAST) & ~longArm;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bclkPrev_r <= 1'b0;
      mclkPrev_r <= 1'b0;
      rxFsPrev_r <= 1'b0;
      evtPrev_r  <= 1'b0;
    end else begin
      bclkPrev_r <= bclkR;
      mclkPrev_r <= mclkSel;
      rxFsPrev_r <= pinF.rxFs;
      evtPrev_r  <= evtTglS;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      txWord_r  <= '0;
      wordTgl_r <= 1'b0;
    end else if (frameEvt) begin
      txWord_r  <= pcfEncode(sampleIn, LAW_A);
      wordTgl_r <= ~wordTgl_r;
    end
  end

  // counting restarts at every frame, so a spare 193rd pulse never shifts the frame
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tickCnt_r     <= 9'h000;
      frameTimingOk <= 1'b0;
    end else if (frameEvt) begin
      frameTimingOk <= hiRate ? (tickCnt_r == TICKS_HI) :
                       (tickCnt_r == TICKS_LO || tickCnt_r == TICKS_LO_EXT);
      // a master edge in the frame cycle belongs to the new frame, not lost
      tickCnt_r     <= {8'h00, mclkRise};
    end else if (mclkRise && tickCnt_r != TICKS_SAT) begin
      tickCnt_r <= tickCnt_r + 9'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxAct_r    <= 1'b0;
      rxCnt_r    <= 3'h0;
      rxFsFall_r <= 1'b0;
      rxShift_r  <= '0;
    end else if (longArm) begin
      rxAct_r <= 1'b1;
      rxCnt_r <= 3'h0;
    end else if (bclkFall) begin
      rxFsFall_r <= pinF.rxFs;
      if (rxAct_r) begin
        rxShift_r <= {rxShift_r[CODE_W-2:0], pinF.rxData};
        rxCnt_r   <= rxCnt_r + 3'h1;
        if (rxCnt_r == RX_LAST) rxAct_r <= 1'b0;
      end else if (!longModeS && pinF.rxFs && !rxFsFall_r) begin
        rxAct_r <= 1'b1;
        rxCnt_r <= 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rxCode_r       <= '0;
      decCnt_r       <= '0;
      rxSample       <= '0;
      rxSampleStrobe <= 1'b0;
    end else begin
      rxSampleStrobe <= (decCnt_r == DW'(1));
      if (decCnt_r == DW'(1)) rxSample <= pcfDecode(rxCode_r, LAW_A);
      if (decGo) begin
        rxCode_r <= {rxShift_r[CODE_W-2:0], pinF.rxData};
        decCnt_r <= DEC_CNT;
      end else if (decCnt_r != '0) begin
        decCnt_r <= decCnt_r - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  property p_txSign;
    @(posedge txBitClk) disable iff (!nrst) (bitCnt_r == BIT_FIRST) |-> txDataOe;
  endproperty
  a_txSign: assert property (p_txSign) else $error("output not enabled with sign bit");

  property p_txEight;
    @(posedge txBitClk) disable iff (!nrst) (bitCnt_r == BIT_FIRST) |-> ##7 (bitCnt_r == BIT_LAST);
  endproperty
  a_txEight: assert property (p_txEight) else $error("slot is not eight bits");

  property p_slot;
    @(posedge txBitClk) disable iff (!nrst) busy |-> (txSlotIndicatorNOe && !txSlotIndicatorNOut);
  endproperty
  a_slot: assert property (p_slot) else $error("slot indicator not low in slot");

  property p_arm;
    @(negedge txBitClk) disable iff (!nrst) txDataOe |-> seen_r;
  endproperty
  a_arm: assert property (p_arm) else $error("output enabled before second sync");

  property p_long;
    @(negedge txBitClk) disable iff (!nrst) (hiCnt_r == HI_LONG && txFrameSync) |=> longMode_r;
  endproperty
  a_long: assert property (p_long) else $error("long sync not detected");

  property p_short;
    @(negedge txBitClk) disable iff (!nrst)
      (hiCnt_r != 2'h0 && hiCnt_r != HI_SAT && !txFrameSync) |=> !longMode_r;
  endproperty
  a_short: assert property (p_short) else $error("short sync not detected");

  property p_float;
    @(negedge txBitClk) disable iff (!nrst)
      (txDataOe && bitCnt_r == BIT_LAST && !txFrameSync) |=> !txDataOe;
  endproperty
  a_float: assert property (p_float) else $error("output not floated after slot");

  property p_dec;
    @(posedge ref_clk) disable iff (!nrst) (decCnt_r == DEC_CNT) |-> ##DEC_WAIT rxSampleStrobe;
  endproperty
  a_dec: assert property (p_dec) else $error("decoder update not on time");

  property p_enc;
    @(posedge ref_clk) disable iff (!nrst) frameEvt |=> (txWord_r == pcfEncode($past(sampleIn), LAW_A));
  endproperty
  a_enc: assert property (p_enc) else $error("encoded word wrong");

  property p_mclk;
    @(posedge ref_clk) disable iff (!nrst) mclkRxStatic |-> (mclkSel == pinF.mclkTx);
  endproperty
  a_mclk: assert property (p_mclk) else $error("tx master clock not selected");

endmodule : pcf_port

`default_nettype wire

// File: pkg/pcf_pkg.sv
`default_nettype none

package pcf_pkg;

  localparam int CLK_PERIOD_NS   = 50;
  localparam int DECODE_DELAY_NS = 10000;
  localparam int DECODE_CYC      = DECODE_DELAY_NS / CLK_PERIOD_NS;
  // a pin is called static once it has not moved for this long (above a 64 kHz half period)
  localparam int STATIC_NS       = 25600;
  localparam int STATIC_CYC      = STATIC_NS / CLK_PERIOD_NS;

  localparam int CODE_W = 8;
  localparam int LIN_W  = 16;

  localparam logic [3:0]  BIT_FIRST    = 4'h1;
  localparam logic [3:0]  BIT_LAST     = 4'h8;
  localparam logic [1:0]  HI_LONG      = 2'h2;
  localparam logic [1:0]  HI_SAT       = 2'h3;
  localparam logic [2:0]  RX_LAST      = 3'h7;
  localparam logic [8:0]  TICKS_HI     = 9'h100;
  localparam logic [8:0]  TICKS_LO     = 9'h0C0;
  localparam logic [8:0]  TICKS_LO_EXT = 9'h0C1;
  localparam logic [8:0]  TICKS_SAT    = 9'h1FF;
  localparam logic [13:0] MU_BIAS      = 14'h0021;
  localparam logic [13:0] MU_CLIP      = 14'h1FDE;
  localparam logic [13:0] A_CLIP       = 14'h0FFF;
  localparam logic [15:0] MU_DBIAS     = 16'h0084;
  localparam logic [15:0] A_DSTEP      = 16'h0100;
  localparam logic [7:0]  A_INV        = 8'h55;

  typedef logic [CODE_W-1:0]       pcfCode_t;
  typedef logic signed [LIN_W-1:0] pcfLin_t;

  typedef struct packed {
    logic rxBclk;
    logic rxFs;
    logic rxData;
    logic mclkRx;
    logic mclkTx;
    logic txBclk;
  } pcfPins_t;

  function automatic pcfCode_t pcfEncode(input pcfLin_t x, input logic aLaw);
    logic        neg;
    logic [15:0] mag;
    logic [13:0] m;
    logic [2:0]  seg;
    logic [3:0]  man;
    pcfCode_t    c;
    neg = x[15];
    mag = neg ? 16'(-x) : 16'(x);
    seg = 3'h0;
    if (!aLaw) begin
      m = (mag[15:2] > MU_CLIP) ? MU_CLIP : mag[15:2];
      m = m + MU_BIAS;
      for (int i = 0; i < 8; i++) if (m[i + 5]) seg = 3'(i);
      man = 4'(m >> (4'(seg) + 4'h1));
      c = ~{neg, seg, man};
    end else begin
      m = {1'b0, mag[15:3]};
      if (m > A_CLIP) m = A_CLIP;
      for (int i = 0; i < 7; i++) if (m[i + 5]) seg = 3'(i + 1);
      man = (seg == 3'h0) ? 4'(m >> 4'h1) : 4'(m >> seg);
      c = {~neg, seg, man} ^ A_INV;
    end
    return c;
  endfunction : pcfEncode

  function automatic pcfLin_t pcfDecode(input pcfCode_t c, input logic aLaw);
    pcfCode_t    d;
    logic [15:0] t;
    logic        neg;
    d = aLaw ? (c ^ A_INV) : ~c;
    neg = aLaw ? ~d[7] : d[7];
    if (!aLaw) begin
      t = 16'(({9'h000, d[3:0], 3'h0} + MU_DBIAS) << d[6:4]) - MU_DBIAS;
    end else begin
      t = {8'h00, d[3:0], 4'h8};
      if (d[6:4] != 3'h0) t = 16'((t + A_DSTEP) << (d[6:4] - 3'h1));
    end
    return neg ? pcfLin_t'(-t) : pcfLin_t'(t);
  endfunction : pcfDecode

endpackage : pcf_pkg

`default_nettype wire

// File: test/pcf_highway_model.sv
`timescale 1ns/10ps
`default_nettype none

module pcf_highway_model
  import pcf_pkg::*;
(
  output logic txBitClk,
  output logic txFrameSync,
  output logic txMasterClock,
  output logic rxBitClock,
  output logic rxFrameSync,
  output logic rxData,
  output logic rxMasterClock
);
  int       txWidth   = 1;
  int       rxWidth   = 1;
  pcfCode_t rxCode    = 8'h00;
  bit       rxReq     = 1'b0;
  bit       rxBclkRun = 1'b1;
  bit       rxMclkRun = 1'b0;
  realtime  mclkHalf  = 244.14;
  realtime  lastCapT  = 0.0;
  int       frameCnt  = 0;

  //////////////////////////////////////////////////////////////////////////////
  // highway bit clocks run free; a stopped rx pin parks low and acts as rate select
  initial begin
    {txBitClk, txFrameSync, txMasterClock, rxBitClock, rxFrameSync, rxData, rxMasterClock} = 7'h00;
    fork
      forever #62.5 txBitClk = ~txBitClk;
      forever #(mclkHalf) txMasterClock = ~txMasterClock;
      forever #500 rxBitClock = rxBclkRun ? ~rxBitClock : 1'b0;
      forever #323.83 rxMasterClock = rxMclkRun ? ~rxMasterClock : 1'b0;
    join_none
  end

  //////////////////////////////////////////////////////////////////////////////
  // 1000 bit periods of 125 ns make one frame
  initial begin
    repeat (40) @(posedge txBitClk);
    forever begin
      #5 txFrameSync = 1'b1;
      frameCnt++;
      repeat (txWidth) @(posedge txBitClk);
      #5 txFrameSync = 1'b0;
      repeat (1000 - txWidth) @(posedge txBitClk);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // short: sign one bit after the sync; long: sign goes out with the sync edge
  initial forever begin
    @(frameCnt);
    if (rxReq) begin
      int k;
      k = (rxWidth > 1) ? 0 : 1;
      rxReq = 1'b0;
      @(posedge rxBitClock);
      #5 rxFrameSync = 1'b1;
      for (int i = 0; i < 10; i++) begin
        if (i >= rxWidth) rxFrameSync = 1'b0;
        if (i >= k && i - k < 8) rxData = rxCode[7 - (i - k)];
        // slot over: the line must not keep showing the last bit
        if (i - k == 8) rxData = ~rxData;
        if (i - k == 7) begin
          @(negedge rxBitClock);
          lastCapT = $realtime;
        end
        @(posedge rxBitClock);
        #5;
      end
    end
  end
endmodule : pcf_highway_model

`default_nettype wire

// File: test/pcf_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module pcf_port_tb
  import pcf_pkg::*;
;
  logic     ref_clk;
  logic     nrst;
  logic     txBitClk, txFrameSync, txMasterClock;
  logic     rxBitClock, rxFrameSync, rxData, rxMasterClock;
  pcfLin_t  sampleIn;
  logic     txDataOut, txDataOe, slotOut, slotOe;
  pcfLin_t  rxSample;
  logic     rxSampleStrobe, frameTimingOk;
  wire      slotPinN;
  pcfCode_t txWord;
  int       oeFalls    = 0;
  int       slotFalls  = 0;
  int       num_errors = 0;
  int       n_compared = 0;

  // open-drain slot pin with its pull-up
  assign slotPinN = slotOe ? slotOut : 1'b1;

  pcf_highway_model u_pcf_highway_model (
    .txBitClk      (txBitClk),
    .txFrameSync   (txFrameSync),
    .txMasterClock (txMasterClock),
    .rxBitClock    (rxBitClock),
    .rxFrameSync   (rxFrameSync),
    .rxData        (rxData),
    .rxMasterClock (rxMasterClock)
  );

  pcf_port #(.LAW_A(1'b1)) u_pcf_port (
    .ref_clk                  (ref_clk),
    .nrst                     (nrst),
    .txBitClk                 (txBitClk),
    .txFrameSync              (txFrameSync),
    .txMasterClock            (txMasterClock),
    .rxBitClockOrRateSelect   (rxBitClock),
    .rxFrameSync              (rxFrameSync),
    .rxData                   (rxData),
    .rxMasterClockOrPowerdown (rxMasterClock),
    .sampleIn                 (sampleIn),
    .txDataOut                (txDataOut),
    .txDataOe                 (txDataOe),
    .txSlotIndicatorNOut      (slotOut),
    .txSlotIndicatorNOe       (slotOe),
    .rxSample                 (rxSample),
    .rxSampleStrobe           (rxSampleStrobe),
    .frameTimingOk            (frameTimingOk)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // falls see pre-edge values, so the fall that ends a slot still counts its bit
  always @(negedge txBitClk) begin
    if (txDataOe === 1'b1) begin
      if (oeFalls < 8) txWord = {txWord[6:0], txDataOut};
      oeFalls++;
    end
    if (slotPinN === 1'b0) slotFalls++;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] expVal, input logic [15:0] gotVal);
    n_compared++;
    if (gotVal !== expVal) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, expVal, gotVal);
    end
  endtask : check

  task automatic stop_test();
    if (num_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  // judges the slot of the frame that starts next, then loads the next sync
  task automatic tx_frame(input int nextW, input pcfLin_t nextS, input int expFalls, input pcfCode_t expCode);
    @(u_pcf_highway_model.frameCnt);
    oeFalls = 0;
    slotFalls = 0;
    repeat (20) @(posedge txBitClk);
    @(posedge ref_clk);
    #5;
    check("tx enabled bits", 16'(expFalls), 16'(oeFalls));
    if (expFalls > 0) check("tx word", 16'(expCode), 16'(txWord));
    check("slot low bits", (expFalls > 0) ? 16'h0008 : 16'h0000, 16'(slotFalls));
    u_pcf_highway_model.txWidth = nextW;
    sampleIn = nextS;
  endtask : tx_frame

  task automatic rx_frame(input int width, input pcfCode_t code, input logic [15:0] expSample);
    int n;
    int dly;
    n = 0;
    @(posedge ref_clk);
    #5;
    u_pcf_highway_model.rxWidth = width;
    u_pcf_highway_model.rxCode  = code;
    u_pcf_highway_model.rxReq   = 1'b1;
    while (rxSampleStrobe !== 1'b1 && n < 4000) begin
      @(posedge ref_clk);
      #5;
      n++;
    end
    dly = int'(($realtime - u_pcf_highway_model.lastCapT) / 50.0);
    check("decode strobe seen", 16'h0001, 16'(rxSampleStrobe));
    check("decoded sample", expSample, rxSample);
    check("decode delay in range", 16'h0001, 16'(dly >= 200 && dly <= 212));
    @(posedge ref_clk);
    #5;
    check("strobe width", 16'h0000, 16'(rxSampleStrobe));
  endtask : rx_frame

  task automatic wait_frames(input int n);
    repeat (n) @(u_pcf_highway_model.frameCnt);
    @(posedge ref_clk);
    #5;
  endtask : wait_frames

  //////////////////////////////////////////////////////////////////////////////
  // codes are full scale, zero and negative full scale; widths probe the 3rd-fall boundary
  task automatic test_tx_frames();
    tx_frame(2, 16'sh8000, 0, 8'h00);
    tx_frame(10, 16'sh0000, 8, 8'hAA);
    tx_frame(10, 16'sh7FFF, 10, 8'h2A);
    tx_frame(3, 16'sh8000, 10, 8'hD5);
    tx_frame(10, 16'sh0000, 8, 8'hAA);
    tx_frame(4, 16'sh7FFF, 10, 8'h2A);
  endtask : test_tx_frames

  task automatic test_rx_decode();
    rx_frame(4, 8'hAA, 16'h7E00);
    rx_frame(4, 8'h55, 16'hFFF8);
    @(posedge ref_clk);
    #5;
    u_pcf_highway_model.txWidth = 1;
    repeat (2) @(u_pcf_highway_model.frameCnt);
    rx_frame(1, 8'h2A, 16'h8200);
    rx_frame(1, 8'hD5, 16'h0008);
  endtask : test_rx_decode

  task automatic test_master_rate();
    wait_frames(4);
    check("timing with tx master", 16'h0001, 16'(frameTimingOk));
    u_pcf_highway_model.rxMclkRun = 1'b1;
    wait_frames(4);
    check("timing with rx master", 16'h0000, 16'(frameTimingOk));
    u_pcf_highway_model.rxMclkRun = 1'b0;
    u_pcf_highway_model.rxBclkRun = 1'b0;
    u_pcf_highway_model.mclkHalf  = 323.83;
    wait_frames(4);
    check("timing at 193 ticks", 16'h0001, 16'(frameTimingOk));
  endtask : test_master_rate

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    sampleIn = 16'sh7FFF;
    repeat (10) @(posedge ref_clk);
    #5 nrst = 1'b1;
    test_tx_frames();
    test_rx_decode();
    test_master_rate();
    stop_test();
  end

  // the whole sequence needs about 3 ms
  initial begin
    #4000000;
    num_errors++;
    stop_test();
  end
endmodule : pcf_port_tb

`default_nettype wire
